// File: core/serial_rtc_consts.vh
// Constants for the serial calendar clock: timing, addresses and field positions
`ifndef SERIAL_RTC_CONSTS_VH
`define SERIAL_RTC_CONSTS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS     10
`define SEC_PERIOD_NS     1000000000
`define SEC_CYCLES        (`SEC_PERIOD_NS / `CLK_PERIOD_NS)
`define BUSY_WINDOW_NS    3900000
`define BUSY_CYCLES       ((`BUSY_WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TP_HALF_NS        488281
`define TP_HALF_CYCLES    (`TP_HALF_NS / `CLK_PERIOD_NS)
`define TP_LOW_SECS       4'h6
`define TP_LAST_SEC       4'h9

// ----------------------------------------
// Frame and memory
// ----------------------------------------
`define FRAME_LAST_BIT    3'h7
`define RAM_DEPTH         30
`define RAM_BANK          5'h0f

// ----------------------------------------
// Addresses in mode 0
// ----------------------------------------
`define ADDR_SEC1         4'h0
`define ADDR_SEC10        4'h1
`define ADDR_MIN1         4'h2
`define ADDR_MIN10        4'h3
`define ADDR_HR1          4'h4
`define ADDR_HR10         4'h5
`define ADDR_DAY1         4'h6
`define ADDR_DAY10        4'h7
`define ADDR_WEEK         4'h8
`define ADDR_MON1         4'h9
`define ADDR_MON10        4'ha
`define ADDR_YR1          4'hb
`define ADDR_YR10         4'hc
`define ADDR_CTRL1        4'hd
`define ADDR_CTRL2        4'he
`define ADDR_CTRL3        4'hf

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL1_TPS         3
`define CTRL1_ADJ         2
`define CTRL1_CLR         1
`define CTRL1_FMT24       0
`define CTRL3_SYSRST      3
`define CTRL3_TEST        2

`endif

// File: core/pin_sync.v
// Two-stage synchroniser for the pin inputs
`default_nettype none

module pin_sync #(
  parameter WIDTH = 5
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  // ----------------------------------------
  // Per-bit flop pair
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge clk) begin
        if (rst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= din[i];
          sync_reg <= meta_reg;
        end
      end
      assign dout[i] = sync_reg;
    end
  endgenerate

endmodule // pin_sync

`default_nettype wire

// File: core/serial_rtc.v
// Calendar clock with serial host access, increment setting and power-down select
// ----------------------------------------
// How it works
// RL1 - Host avoids digit writes while busy
// RL2 - Host sets up within 996 ms
// RL3 - Host modifies within 3.8 ms of idle
// RL4 - Units digit wrap carries into tens
// RL5 - Host sets year digits first
// RL6 - Tens of hours set via units
// RL7 - Clear mode clears written digit pair
// RL8 - Year digits clear independently
// RL9 - Power select low: ignore, float outputs
// RL10 - Power select drop discards partial frame
// RL11 - First frame after return reads undefined
// RL12 - Power-on initialises, leaves power-on flag
// RL13 - Hour carry fixes nonexistent date
// RL14 - Leap-day year change fixed likewise
// RL15 - Invalid day tens overflow clears units
// RL16 - Valid day tens overflow keeps units
// RL17 - Day tens past 31 gives 01
// RL18 - Sample on leading, shift out trailing
// RL19 - Exactly eight clocks per frame
// RL20 - Select rise clears pulse counter
// RL21 - Digit write increments, not stores
// RL22 - Control and memory writes store nibble
// RL23 - Busy flag guards carry window
// RL24 - System reset released by select and clock
// RL25 - System reset clears power-on flag
// RL26 - Host picks mode 0 first
// RL27 - Address then data; output follows
// ----------------------------------------
`default_nettype none
`include "serial_rtc_consts.vh"

module serial_rtc #(
  parameter SEC_CYCLES     = `SEC_CYCLES,
  parameter BUSY_CYCLES    = `BUSY_CYCLES,
  parameter TP_HALF_CYCLES = `TP_HALF_CYCLES
) (
  input  wire sys_clk,
  input  wire rst,
  input  wire serial_clk,
  input  wire chip_select_n,
  input  wire power_good_select,
  input  wire write_enable,
  input  wire serial_in,
  output wire serial_out,
  output wire serial_out_oe,
  output wire timing_pulse_out,
  output wire timing_pulse_oe
);

  localparam [31:0] SEC_LAST_W   = SEC_CYCLES - 1;
  localparam [31:0] BUSY_START_W = SEC_CYCLES - BUSY_CYCLES;
  localparam [31:0] TP_LAST_W    = TP_HALF_CYCLES - 1;
  localparam [26:0] SEC_LAST     = SEC_LAST_W[26:0];
  localparam [26:0] BUSY_START   = BUSY_START_W[26:0];
  localparam [15:0] TP_LAST      = TP_LAST_W[15:0];

  // ----------------------------------------
  // Pin sampling and edges
  // ----------------------------------------
  wire [4:0] pins_s;
  pin_sync #(.WIDTH(5)) u_sync (
    .clk  (sys_clk),
    .rst  (rst),
    .din  ({serial_clk, chip_select_n, power_good_select, write_enable, serial_in}),
    .dout (pins_s)
  );
  wire sck_s = pins_s[4];
  wire csn_s = pins_s[3];
  wire pwr_s = pins_s[2];
  wire wr_s  = pins_s[1];
  wire sin_s = pins_s[0];

  reg        sck_d_reg;
  reg        csn_d_reg;
  reg  [6:0] shift_reg;
  reg  [2:0] bit_cnt_reg;
  reg  [7:0] out_shift_reg;
  reg  [3:0] sel_addr_reg;
  reg        load_reg;
  reg        serial_out_reg;
  reg        serial_out_oe_reg;

  wire       active   = pwr_s & ~csn_s;                                    // [RL9]
  wire       lead     = active & sck_d_reg & ~sck_s;                       // [RL18]
  wire       trail    = active & ~sck_d_reg & sck_s;                       // [RL18]
  wire       cs_rise  = ~csn_d_reg & csn_s;
  wire       exec     = lead & (bit_cnt_reg == `FRAME_LAST_BIT);           // [RL19]
  wire [3:0] cmd_addr = shift_reg[6:3];                                    // [RL27]
  wire [3:0] cmd_data = {shift_reg[2:0], sin_s};
  wire       cmd_wr   = exec & wr_s;                                       // [RL18]

  // ----------------------------------------
  // Control state and memory
  // ----------------------------------------
  reg       tps_reg;
  reg       clr_mode_reg;
  reg       fmt24_reg;
  reg       power_on_flag_reg;
  reg       system_reset_bit_reg;
  reg       test_reg;
  reg [1:0] addr_mode_reg;
  reg [3:0] ram [0:`RAM_DEPTH-1];
  reg [26:0] sub_reg;

  wire       mode0     = ~addr_mode_reg[1];
  wire       busy      = sub_reg >= BUSY_START;                            // [RL23]
  wire       tick      = (sub_reg == SEC_LAST) & ~system_reset_bit_reg;
  wire       wr_ctrl1  = cmd_wr & mode0 & (cmd_addr == `ADDR_CTRL1);
  wire       wr_ctrl3  = cmd_wr & (cmd_addr == `ADDR_CTRL3);
  wire       wr_ram    = cmd_wr & ~mode0 & (cmd_addr != `ADDR_CTRL3);
  // Clock has priority: digit writes in the busy window are dropped
  wire       wr_digit  = cmd_wr & mode0 & (cmd_addr <= `ADDR_YR10) & ~busy
                         & ~system_reset_bit_reg;                          // [RL1] [RL23]
  wire       adj_cmd   = wr_ctrl1 & cmd_data[`CTRL1_ADJ] & ~system_reset_bit_reg;
  wire [4:0] ram_idx   = addr_mode_reg[0] ? (`RAM_BANK + {1'b0, cmd_addr}) : {1'b0, cmd_addr};

  always @(posedge sys_clk) begin
    if (rst) begin
      tps_reg              <= 1'b0;
      clr_mode_reg         <= 1'b0;
      fmt24_reg            <= 1'b0;
      power_on_flag_reg    <= 1'b1;                                        // [RL12]
      system_reset_bit_reg <= 1'b0;
      test_reg             <= 1'b0;
      addr_mode_reg        <= 2'h0;
    end else begin
      if (wr_ctrl1 && !system_reset_bit_reg) begin                         // [RL22]
        tps_reg      <= cmd_data[`CTRL1_TPS];
        clr_mode_reg <= cmd_data[`CTRL1_CLR];
        fmt24_reg    <= cmd_data[`CTRL1_FMT24];
      end
      if (wr_ctrl3) begin                                                  // [RL22]
        system_reset_bit_reg <= cmd_data[`CTRL3_SYSRST];
        test_reg             <= cmd_data[`CTRL3_TEST];
        addr_mode_reg        <= cmd_data[1:0];
        if (cmd_data[`CTRL3_SYSRST]) begin
          power_on_flag_reg <= 1'b0;                                       // [RL25]
          tps_reg           <= 1'b0;
          clr_mode_reg      <= 1'b0;
          fmt24_reg         <= 1'b0;
          test_reg          <= 1'b0;
          addr_mode_reg     <= 2'h0;
        end
      end else if (system_reset_bit_reg && pwr_s && csn_s && !sck_s) begin
        system_reset_bit_reg <= 1'b0;                                      // [RL24]
      end
    end
  end

  // Memory content is undefined after reset, so no reset branch
  always @(posedge sys_clk) begin
    if (wr_ram) begin
      ram[ram_idx] <= cmd_data;                                            // [RL22]
    end
  end

  // ----------------------------------------
  // Time and calendar digits
  // ----------------------------------------
  reg [3:0] s1_reg, s10_reg, m1_reg, m10_reg, d1_reg, d10_reg;
  reg [3:0] mo1_reg, mo10_reg, y1_reg, y10_reg;
  reg [4:0] hr_reg;
  reg [2:0] wk_reg;
  reg [3:0] s1_next, s10_next, m1_next, m10_next, d1_next, d10_next;
  reg [3:0] mo1_next, mo10_next, y1_next, y10_next;
  reg [4:0] hr_next;
  reg [2:0] wk_next;
  reg       min_c, hr_c, day_c, mon_c, hr_moved, clr_sub;

  function [6:0] bin2;
    input [3:0] tens;
    input [3:0] units;
    begin
      bin2 = ({3'h0, tens} * 7'd10) + {3'h0, units};
    end
  endfunction

  function [6:0] max_day;
    input [6:0] mon;
    input       leap;
    begin
      case (mon)
        7'd2:                      max_day = leap ? 7'd29 : 7'd28;
        7'd4, 7'd6, 7'd9, 7'd11:   max_day = 7'd30;
        default:                   max_day = 7'd31;
      endcase
    end
  endfunction

  wire       leap        = y10_reg[0] ? (y1_reg == 4'h2 || y1_reg == 4'h6)
                                      : (y1_reg == 4'h0 || y1_reg == 4'h4 || y1_reg == 4'h8);
  wire [6:0] day_bin     = bin2(d10_reg, d1_reg);
  wire [6:0] mon_bin     = bin2(mo10_reg, mo1_reg);
  wire [6:0] cur_max     = max_day(mon_bin, leap);
  wire       day_invalid = day_bin > cur_max;
  wire [6:0] day_tens_up = bin2(d10_reg + 4'h1, d1_reg);

  always @* begin
    s1_next = s1_reg;   s10_next = s10_reg;  m1_next = m1_reg;   m10_next = m10_reg;
    hr_next = hr_reg;   d1_next = d1_reg;    d10_next = d10_reg; wk_next = wk_reg;
    mo1_next = mo1_reg; mo10_next = mo10_reg; y1_next = y1_reg;  y10_next = y10_reg;
    min_c = 1'b0; hr_c = 1'b0; day_c = 1'b0; mon_c = 1'b0; hr_moved = 1'b0; clr_sub = 1'b0;
    if (system_reset_bit_reg) begin
      s1_next = 4'h0; s10_next = 4'h0; m1_next = 4'h0; m10_next = 4'h0; hr_next = 5'h00;
      d1_next = 4'h1; d10_next = 4'h0; mo1_next = 4'h1; mo10_next = 4'h0;
      y1_next = 4'h0; y10_next = 4'h0; wk_next = 3'h0; clr_sub = 1'b1;
    end else if (tick) begin
      if (s1_reg == 4'h9) begin
        s1_next = 4'h0;
        if (s10_reg == 4'h5) begin
          s10_next = 4'h0;
          min_c    = 1'b1;
        end else s10_next = s10_reg + 4'h1;
      end else s1_next = s1_reg + 4'h1;
    end else if (adj_cmd) begin
      s1_next = 4'h0; s10_next = 4'h0; clr_sub = 1'b1;
      min_c   = (s10_reg >= 4'h3);
    end else if (wr_digit) begin
      case (cmd_addr)                                                      // [RL21]
        `ADDR_SEC1, `ADDR_SEC10: begin
          if (clr_mode_reg) begin                                          // [RL7]
            s1_next = 4'h0; s10_next = 4'h0; clr_sub = 1'b1;
          end else if (cmd_addr == `ADDR_SEC1 && s1_reg != 4'h9) s1_next = s1_reg + 4'h1;
          else begin
            if (cmd_addr == `ADDR_SEC1) s1_next = 4'h0;                    // [RL4]
            s10_next = (s10_reg == 4'h5) ? 4'h0 : s10_reg + 4'h1;
          end
        end
        `ADDR_MIN1, `ADDR_MIN10: begin
          if (clr_mode_reg) begin                                          // [RL7]
            m1_next = 4'h0; m10_next = 4'h0;
          end else if (cmd_addr == `ADDR_MIN1 && m1_reg != 4'h9) m1_next = m1_reg + 4'h1;
          else begin
            if (cmd_addr == `ADDR_MIN1) m1_next = 4'h0;                    // [RL4]
            m10_next = (m10_reg == 4'h5) ? 4'h0 : m10_reg + 4'h1;
          end
        end
        `ADDR_HR1, `ADDR_HR10: begin
          if (clr_mode_reg) hr_next = 5'h00;                               // [RL7]
          else if (cmd_addr == `ADDR_HR1) begin                            // [RL6] [RL4]
            hr_moved = 1'b1;
            hr_next  = (hr_reg == 5'd23) ? 5'h00 : hr_reg + 5'h01;
          end
        end
        `ADDR_DAY1: begin
          if (clr_mode_reg) begin                                          // [RL7]
            d1_next = 4'h1; d10_next = 4'h0;
          end else if (d1_reg == 4'h9) begin                               // [RL4]
            d1_next = 4'h0; d10_next = (d10_reg == 4'h3) ? 4'h0 : d10_reg + 4'h1;
          end else d1_next = d1_reg + 4'h1;
        end
        `ADDR_DAY10: begin
          if (clr_mode_reg) begin                                          // [RL7]
            d1_next = 4'h1; d10_next = 4'h0;
          end else if (d10_reg == 4'h3 || day_tens_up > 7'd31) begin
            d10_next = 4'h0;
            if (day_invalid) d1_next = 4'h0;                               // [RL15]
            else if (d1_reg == 4'h0) d1_next = 4'h1;                       // [RL17]
          end else d10_next = d10_reg + 4'h1;                              // [RL16]
        end
        `ADDR_WEEK: wk_next = (clr_mode_reg || wk_reg == 3'h6) ? 3'h0 : wk_reg + 3'h1;
        `ADDR_MON1: begin
          if (clr_mode_reg || mon_bin >= 7'd12) begin                      // [RL7]
            mo1_next = 4'h1; mo10_next = 4'h0;
          end else if (mo1_reg == 4'h9) begin                              // [RL4]
            mo1_next = 4'h0; mo10_next = 4'h1;
          end else mo1_next = mo1_reg + 4'h1;
        end
        `ADDR_MON10: begin
          if (clr_mode_reg || mo10_reg != 4'h0) begin
            mo10_next = 4'h0;
            if (clr_mode_reg || mo1_reg == 4'h0) mo1_next = 4'h1;
          end else begin
            mo10_next = 4'h1;
            if (mo1_reg > 4'h2) mo1_next = 4'h2;
          end
        end
        `ADDR_YR1: begin
          if (clr_mode_reg) y1_next = 4'h0;                                // [RL8]
          else if (y1_reg == 4'h9) begin                                   // [RL4]
            y1_next = 4'h0; y10_next = (y10_reg == 4'h9) ? 4'h0 : y10_reg + 4'h1;
          end else y1_next = y1_reg + 4'h1;
        end
        `ADDR_YR10: begin
          if (clr_mode_reg || y10_reg == 4'h9) y10_next = 4'h0;            // [RL8]
          else y10_next = y10_reg + 4'h1;
        end
        default: ;
      endcase
    end
    if (min_c) begin
      if (m1_reg == 4'h9) begin
        m1_next = 4'h0;
        if (m10_reg == 4'h5) begin
          m10_next = 4'h0; hr_c = 1'b1;
        end else m10_next = m10_reg + 4'h1;
      end else m1_next = m1_reg + 4'h1;
    end
    if (hr_c) begin
      hr_moved = 1'b1;
      if (hr_reg == 5'd23) begin
        hr_next = 5'h00; day_c = 1'b1;
      end else hr_next = hr_reg + 5'h01;
    end
    if (day_c) begin
      wk_next = (wk_reg == 3'h6) ? 3'h0 : wk_reg + 3'h1;
      if (day_bin >= cur_max) begin
        d1_next = 4'h1; d10_next = 4'h0; mon_c = 1'b1;
      end else if (d1_reg == 4'h9) begin
        d1_next = 4'h0; d10_next = d10_reg + 4'h1;
      end else d1_next = d1_reg + 4'h1;
    end else if (hr_moved && day_invalid) begin                            // [RL13] [RL14]
      d1_next = 4'h1; d10_next = 4'h0; mon_c = 1'b1;
    end
    if (mon_c) begin
      if (mon_bin >= 7'd12) begin
        mo1_next = 4'h1; mo10_next = 4'h0;
        if (y1_reg == 4'h9) begin
          y1_next = 4'h0; y10_next = (y10_reg == 4'h9) ? 4'h0 : y10_reg + 4'h1;
        end else y1_next = y1_reg + 4'h1;
      end else if (mo1_reg == 4'h9) begin
        mo1_next = 4'h0; mo10_next = 4'h1;
      end else mo1_next = mo1_reg + 4'h1;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin                                                         // [RL12]
      s1_reg <= 4'h0; s10_reg <= 4'h0; m1_reg <= 4'h0; m10_reg <= 4'h0; hr_reg <= 5'h00;
      d1_reg <= 4'h1; d10_reg <= 4'h0; mo1_reg <= 4'h1; mo10_reg <= 4'h0;
      y1_reg <= 4'h0; y10_reg <= 4'h0; wk_reg <= 3'h0; sub_reg <= 27'h0;
    end else begin
      s1_reg <= s1_next; s10_reg <= s10_next; m1_reg <= m1_next; m10_reg <= m10_next;
      hr_reg <= hr_next; d1_reg <= d1_next; d10_reg <= d10_next; wk_reg <= wk_next;
      mo1_reg <= mo1_next; mo10_reg <= mo10_next; y1_reg <= y1_next; y10_reg <= y10_next;
      if (clr_sub || sub_reg == SEC_LAST) sub_reg <= 27'h0;
      else sub_reg <= sub_reg + 27'h1;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [4:0] hr12     = (hr_reg >= 5'd12) ? hr_reg - 5'd12 : hr_reg;
  wire [4:0] hr_disp  = fmt24_reg ? hr_reg : ((hr12 == 5'h00) ? 5'd12 : hr12);
  wire [1:0] hr_tens  = (hr_disp >= 5'd20) ? 2'h2 : ((hr_disp >= 5'd10) ? 2'h1 : 2'h0);
  wire [4:0] hr_units = hr_disp - ({3'h0, hr_tens} * 5'd10);
  wire       pm       = hr_reg >= 5'd12;
  reg  [3:0] rd_nib;

  always @* begin
    rd_nib = 4'h0;
    if (sel_addr_reg == `ADDR_CTRL3) rd_nib = {system_reset_bit_reg, test_reg, addr_mode_reg};
    else if (!mode0) rd_nib = ram[addr_mode_reg[0] ? (`RAM_BANK + {1'b0, sel_addr_reg})
                                                   : {1'b0, sel_addr_reg}];
    else begin
      case (sel_addr_reg)
        `ADDR_SEC1:  rd_nib = s1_reg;
        `ADDR_SEC10: rd_nib = s10_reg;
        `ADDR_MIN1:  rd_nib = m1_reg;
        `ADDR_MIN10: rd_nib = m10_reg;
        `ADDR_HR1:   rd_nib = hr_units[3:0];
        `ADDR_HR10:  rd_nib = {1'b0, pm, hr_tens};
        `ADDR_DAY1:  rd_nib = d1_reg;
        `ADDR_DAY10: rd_nib = d10_reg;
        `ADDR_WEEK:  rd_nib = {1'b0, wk_reg};
        `ADDR_MON1:  rd_nib = mo1_reg;
        `ADDR_MON10: rd_nib = mo10_reg;
        `ADDR_YR1:   rd_nib = y1_reg;
        `ADDR_YR10:  rd_nib = y10_reg;
        `ADDR_CTRL1: rd_nib = {tps_reg, 1'b0, clr_mode_reg, fmt24_reg};
        `ADDR_CTRL2: rd_nib = {busy, power_on_flag_reg, 2'h0};             // [RL23]
        default:     rd_nib = 4'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Serial frame engine
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      sck_d_reg <= 1'b1; csn_d_reg <= 1'b1; shift_reg <= 7'h00; bit_cnt_reg <= 3'h0;
      out_shift_reg <= 8'h00; sel_addr_reg <= 4'h0; load_reg <= 1'b0;
      serial_out_reg <= 1'b0; serial_out_oe_reg <= 1'b0;
    end else begin
      sck_d_reg         <= sck_s;
      csn_d_reg         <= csn_s;
      load_reg          <= exec;
      serial_out_reg    <= out_shift_reg[7];
      serial_out_oe_reg <= active;                                         // [RL9]
      if (!pwr_s) begin
        // Dropping power select discards the frame and the stale read data
        bit_cnt_reg   <= 3'h0;                                             // [RL10]
        out_shift_reg <= 8'h00;                                            // [RL11]
      end else begin
        if (cs_rise) bit_cnt_reg <= 3'h0;                                  // [RL20]
        else if (lead) begin
          shift_reg   <= {shift_reg[5:0], sin_s};                          // [RL18]
          bit_cnt_reg <= bit_cnt_reg + 3'h1;                               // [RL19]
        end
        if (load_reg) out_shift_reg <= {sel_addr_reg, rd_nib};             // [RL27]
        // Trailing edge after the 8th bit must not eat the fresh MSB
        else if (trail && bit_cnt_reg != 3'h0) begin                       // [RL18]
          out_shift_reg <= {out_shift_reg[6:0], 1'b0};
        end
        if (exec) sel_addr_reg <= cmd_addr;                                // [RL27]
      end
    end
  end

  // ----------------------------------------
  // Timing pulse
  // ----------------------------------------
  reg [15:0] tp_cnt_reg;
  reg        tp_fast_reg;
  reg [3:0]  phase_reg;
  reg        hold_reg;
  reg        tp_out_reg;
  reg        tp_oe_reg;

  always @(posedge sys_clk) begin
    if (rst || system_reset_bit_reg) begin
      tp_cnt_reg <= 16'h0000; tp_fast_reg <= 1'b0; phase_reg <= 4'h0; hold_reg <= 1'b1;
      tp_out_reg <= 1'b0;
      tp_oe_reg  <= rst ? 1'b0 : pwr_s;
    end else begin
      tp_oe_reg <= pwr_s;                                                  // [RL9]
      if (tp_cnt_reg == TP_LAST) begin
        tp_cnt_reg  <= 16'h0000;
        tp_fast_reg <= ~tp_fast_reg;
      end else tp_cnt_reg <= tp_cnt_reg + 16'h0001;
      if (tick || adj_cmd) begin
        // Adjust restarts the slow cycle, so one period comes out short
        phase_reg <= (adj_cmd || phase_reg == `TP_LAST_SEC) ? 4'h0 : phase_reg + 4'h1;
        if (phase_reg == `TP_LAST_SEC) hold_reg <= 1'b0;
      end
      tp_out_reg <= tps_reg ? (~hold_reg & (phase_reg >= `TP_LOW_SECS)) : tp_fast_reg;
    end
  end

  assign serial_out       = serial_out_reg;
  assign serial_out_oe    = serial_out_oe_reg;
  assign timing_pulse_out = tp_out_reg;
  assign timing_pulse_oe  = tp_oe_reg;

endmodule // serial_rtc

`default_nettype wire

// File: dv/serial_rtc_sva.sv
// Port-level checks for the serial calendar clock
`default_nettype none
module serial_rtc_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic power_good_select,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic timing_pulse_out,
  input wire logic timing_pulse_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Margin covers two sync flops and the output register
  sequence pg_gone; !power_good_select [*5]; endsequence
  sequence sel_held; (power_good_select && !chip_select_n) [*6]; endsequence
  a_pg_float_serial_out: assert property (pg_gone |-> !serial_out_oe)
    else $error("serial output driven while power select low");
  a_pg_float_pulse: assert property (pg_gone |-> !timing_pulse_oe)
    else $error("pulse output driven while power select low");
  a_pg_zero_out: assert property (pg_gone |-> !serial_out)
    else $error("serial output not cleared while power select low");
  a_return_still_float: assert property (pg_gone ##1 power_good_select |-> !serial_out_oe [*2])
    else $error("serial output driven too early after power select return");
  a_reset_outs_low: assert property ($fell(rst) |-> !(serial_out_oe | timing_pulse_oe | serial_out | timing_pulse_out))
    else $error("outputs not low after reset");
  a_select_drive_serial_out: assert property (sel_held |-> serial_out_oe)
    else $error("serial output not driven while selected");
  a_deselect_float: assert property (chip_select_n [*6] |-> !serial_out_oe)
    else $error("serial output driven while deselected");
  a_pg_drive_pulse: assert property (power_good_select [*6] |-> timing_pulse_oe)
    else $error("pulse output not driven with power select high");
endmodule // serial_rtc_sva
bind serial_rtc serial_rtc_sva chk_u (.sys_clk(sys_clk), .rst(rst), .chip_select_n(chip_select_n),
  .power_good_select(power_good_select), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .timing_pulse_out(timing_pulse_out), .timing_pulse_oe(timing_pulse_oe));
`default_nettype wire

// File: dv/rtc_host.sv
// Host model driving the serial link of the calendar clock
`default_nettype none
module rtc_host (
  input  wire logic sys_clk,
  input  wire logic serial_out,
  output var  logic serial_clk,
  output var  logic chip_select_n,
  output var  logic write_enable,
  output var  logic serial_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_clk = 1'b1;
    chip_select_n = 1'b1;
    write_enable = 1'b0;
    serial_in = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Full frames send 8 bits; fewer only to test aborts
  task automatic xfer(input logic [7:0] b, input logic w, input int n, output logic [7:0] q);
    int i;
    chip_select_n = 1'b0;
    for (i = 0; i < n; i++) begin
      serial_in = b[7-i];
      write_enable = w;
      tick(4);
      serial_clk = 1'b0;
      tick(4);
      q[7-i] = serial_out;
      serial_clk = 1'b1;
    end
    serial_in = ~serial_in; // Released line keeps moving
    tick(4);
  endtask
  task automatic release_sel();
    chip_select_n = 1'b1;
    tick(4);
    serial_clk = 1'b0;
    tick(4);
    serial_clk = 1'b1;
    tick(4);
  endtask
endmodule // rtc_host
`default_nettype wire

// File: dv/serial_rtc_test.sv
// Self-checking bench for the serial calendar clock
`default_nettype none
module serial_rtc_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, power_good_select;
  wire logic serial_clk, chip_select_n, write_enable, serial_in;
  wire logic serial_out, serial_out_oe, timing_pulse_out, timing_pulse_oe;
  int bad_count = 0;
  int cmp_count = 0;
  logic [7:0] q;
  // Long second keeps every access clear of the busy window
  serial_rtc #(.SEC_CYCLES(20000), .BUSY_CYCLES(100)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
    .power_good_select(power_good_select), .write_enable(write_enable), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .timing_pulse_out(timing_pulse_out),
    .timing_pulse_oe(timing_pulse_oe));
  rtc_host host_u (.sys_clk(sys_clk), .serial_out(serial_out), .serial_clk(serial_clk),
    .chip_select_n(chip_select_n), .write_enable(write_enable), .serial_in(serial_in));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    host_u.xfer({a, d}, 1'b1, 8, q);
  endtask
  // Data comes back one frame late, so the first frame is thrown away
  task automatic expect_rd(input logic [3:0] a, input logic [3:0] d);
    logic [7:0] v;
    host_u.xfer({a, 4'h0}, 1'b0, 8, q);
    host_u.xfer({a, 4'h0}, 1'b0, 8, v);
    check(v, {a, d});
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    power_good_select = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    host_u.tick(3);
    expect_rd(4'he, 4'h4);
    wr(4'hf, 4'h8);
    host_u.release_sel();
    expect_rd(4'hf, 4'h0);
    expect_rd(4'he, 4'h0);
    wr(4'hd, 4'h1);
    repeat (10) wr(4'h4, 4'h0);
    expect_rd(4'h5, 4'h1);
    expect_rd(4'h4, 4'h0);
    wr(4'hd, 4'h3);
    wr(4'h4, 4'h0);
    expect_rd(4'h5, 4'h0);
    expect_rd(4'hd, 4'h3);
    wr(4'hd, 4'h1);
    repeat (3) wr(4'hb, 4'h0);
    repeat (2) wr(4'hc, 4'h0);
    wr(4'hd, 4'h3);
    wr(4'hc, 4'h0);
    expect_rd(4'hb, 4'h3);
    expect_rd(4'hc, 4'h0);
    wr(4'hd, 4'h1);
    repeat (4) wr(4'h7, 4'h0);
    expect_rd(4'h7, 4'h0);
    expect_rd(4'h6, 4'h1);
    wr(4'h9, 4'h0);
    repeat (4) wr(4'h7, 4'h0);
    expect_rd(4'h6, 4'h0);
    repeat (3) wr(4'h7, 4'h0);
    wr(4'h4, 4'h0);
    expect_rd(4'h9, 4'h3);
    wr(4'hf, 4'h2);
    wr(4'h3, 4'ha);
    expect_rd(4'h3, 4'ha);
    wr(4'hf, 4'h0);
    host_u.xfer(8'hd7, 1'b1, 5, q);
    power_good_select = 1'b0;
    host_u.tick(8);
    power_good_select = 1'b1;
    host_u.tick(4);
    expect_rd(4'hd, 4'h1);
    host_u.xfer(8'hd0, 1'b1, 3, q);
    host_u.release_sel();
    expect_rd(4'hd, 4'h1);
    report_and_stop();
  end
endmodule // serial_rtc_test
`default_nettype wire
